// >>> hdl/wdg_pkg.sv
// Constants for the write-once watchdog: addresses, reset values, fields, counts
package wdg_pkg;
    // Byte addresses on the CPU data bus
    localparam logic [15:0] MODE_ADDR = 16'hff98;
    localparam logic [15:0] KEY_ADDR = 16'hff99;

    // Values after reset and fixed values
    localparam logic [7:0] MODE_RST = 8'h67;
    localparam logic [7:0] KEY_RST = 8'h9a;
    localparam logic [7:0] KEY_RESTART = 8'hac;
    localparam logic [2:0] MODE_TOP_BITS = 3'h3;

    // Field positions in the mode register
    localparam int MODE_TOP_LSB = 5;
    localparam int STOP_SEL_BIT = 4;
    localparam int SRC_SEL_BIT = 3;
    localparam int PERIOD_MSB = 2;
    localparam int PERIOD_LSB = 0;
    localparam logic [2:0] PERIOD_RST = 3'h7;

    // Overflow exponents: period is 2^(base + code) source cycles
    localparam logic [4:0] INT_OSC_EXP_BASE = 5'h0b;
    localparam logic [4:0] HS_CLK_EXP_BASE = 5'h0d;

    // Counter wide enough for 2^20 cycles
    localparam int CNT_W = 21;

    // Watchdog life cycle, Gray coded along run -> fired
    typedef enum logic [1:0] {
        WDG_RUN = 2'b00,
        WDG_FIRED = 2'b01,
        WDG_STOPPED = 2'b10
    } wdg_state_t;
endpackage

// >>> hdl/wdg_counter.sv
// Watchdog up-counter with a power-of-two overflow point
`timescale 1ns/1ps
module wdg_counter #(
    parameter int CNT_W = 21
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clear,
    input wire logic tick,
    input wire logic [4:0] exp_sel,
    output logic overflow,
    output logic [CNT_W-1:0] count
);
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [CNT_W-1:0] limit;

    // Last count before the period completes
    assign limit = (CNT_W'(1) << exp_sel) - CNT_W'(1);

    // Clear beats tick so a restart is never lost to a coincident source edge
    always_comb begin
        count_nxt = count_r;
        if (clear) begin
            count_nxt = '0;
        end else if (tick) begin
            count_nxt = count_r + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign overflow = tick && !clear && (count_r == limit);
    assign count = count_r;
endmodule

// >>> hdl/wdg_watchdog.sv
// Write-once watchdog with restart key, byte-wide CPU register port
`timescale 1ns/1ps
// What this block does
// - Mode register resets to 0x67, internal oscillator and longest period.
// - Mode register takes one write; a second write requests internal reset.
// - Mode register reads back its contents any number of times.
// - Bits 4:3 select 00 internal oscillator, 01 fast clock, 1x stopped.
// - Period code n gives 2^(11+n) oscillator or 2^(13+n) fast cycles.
// - Period code is 111 after reset until software writes the mode.
// - With fixed oscillator option, clock select writes are ignored.
// - Every mode write inserts a wait cycle, whatever the clock state.
// - Once stopped by bit 4, clearing it neither restarts nor resets.
// - While stopped by bit 4, violations cause no internal reset.
// - Violation while source clock stopped resets once the clock resumes.
// - Byte write of 0xAC to key register clears counter, counting continues.
// - Any other key value requests internal reset while operating.
// - Single-bit access to key register requests internal reset.
// - Key register always reads 0x9A.
// - Counter reaching selected period requests internal reset.
// - Watchdog reset sets the watchdog reset cause flag.
// - The single accepted mode write clears the counter.
// - Stoppable option pauses counting in standby and keeps the count.
module wdg_watchdog #(
    parameter int CNT_W = wdg_pkg::CNT_W
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_bit_access,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic bus_wait,
    input wire logic osc_fixed_strap,
    input wire logic internal_osc_clk,
    input wire logic hs_clk_tick,
    input wire logic int_osc_running,
    input wire logic hs_clk_running,
    input wire logic standby,
    input wire logic cause_flag_clr,
    output logic wdt_reset_req,
    output logic watchdog_reset_cause_flag,
    output logic wdt_counting
);
    wdg_pkg::wdg_state_t state_r;
    wdg_pkg::wdg_state_t state_nxt;

    logic [7:0] watchdog_mode_r;
    logic [7:0] mode_nxt;
    logic mode_written_r;
    logic opt_fixed_r;
    logic strap_taken_r;
    logic pending_r;
    logic reset_req_r;
    logic cause_flag_r;
    logic [7:0] rdata_r;

    logic sel_mode;
    logic sel_key;
    logic mode_wr;
    logic key_wr;
    logic key_bit;
    logic restart;
    logic violation;
    logic src_hs;
    logic src_live;
    logic src_tick;
    logic cnt_clear;
    logic cnt_tick;
    logic cnt_ovf;
    logic [4:0] exp_sel;
    logic fire;

    // Overflow exponent from the period code and the selected source
    function automatic logic [4:0] period_exp(input logic hs, input logic [2:0] code);
        logic [4:0] base;
        base = hs ? wdg_pkg::HS_CLK_EXP_BASE : wdg_pkg::INT_OSC_EXP_BASE;
        return base + {2'b00, code};
    endfunction

    // Option strap is caught once, on the first edge after reset release
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            opt_fixed_r <= 1'b1;
            strap_taken_r <= 1'b0;
        end else if (!strap_taken_r) begin
            opt_fixed_r <= osc_fixed_strap;
            strap_taken_r <= 1'b1;
        end
    end

    // Address decode; bit accesses are flagged separately by the CPU
    assign sel_mode = (bus_addr == wdg_pkg::MODE_ADDR);
    assign sel_key = (bus_addr == wdg_pkg::KEY_ADDR);
    // A bit-manipulation write to the mode register is not a legal setting
    assign mode_wr = bus_wr && sel_mode && !bus_bit_access;
    assign key_wr = bus_wr && sel_key && !bus_bit_access;
    assign key_bit = (bus_wr || bus_rd) && sel_key && bus_bit_access;
    assign restart = key_wr && (bus_wdata == wdg_pkg::KEY_RESTART);

    // Reset-causing accesses
    always_comb begin
        violation = 1'b0;
        if (mode_wr && mode_written_r) begin
            violation = 1'b1;
        end
        if (key_wr && (bus_wdata != wdg_pkg::KEY_RESTART)) begin
            violation = 1'b1;
        end
        if (key_bit) begin
            violation = 1'b1;
        end
    end

    // Every mode write stretches the bus access by one cycle
    assign bus_wait = bus_wr && sel_mode;

    // Value stored by the single permitted mode write
    always_comb begin
        mode_nxt = bus_wdata;
        // Top bits are fixed; other values are not stored
        mode_nxt[7:wdg_pkg::MODE_TOP_LSB] = wdg_pkg::MODE_TOP_BITS;
        if (opt_fixed_r) begin
            mode_nxt[wdg_pkg::STOP_SEL_BIT] = 1'b0;
            mode_nxt[wdg_pkg::SRC_SEL_BIT] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            watchdog_mode_r <= wdg_pkg::MODE_RST;
        end else if (mode_wr && !mode_written_r) begin
            watchdog_mode_r <= mode_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mode_written_r <= 1'b0;
        end else if (mode_wr) begin
            mode_written_r <= 1'b1;
        end
    end

    // Source selection; bit 4 is handled by the stopped state instead
    assign src_hs = watchdog_mode_r[wdg_pkg::SRC_SEL_BIT] && !opt_fixed_r;

    // Source clock is live when it runs and, if stoppable, not in standby
    always_comb begin
        if (opt_fixed_r) begin
            // Fixed oscillator keeps counting even in standby
            src_live = int_osc_running;
        end else if (src_hs) begin
            src_live = hs_clk_running && !standby;
        end else begin
            src_live = int_osc_running && !standby;
        end
    end

    assign src_tick = src_hs ? hs_clk_tick : internal_osc_clk;
    assign exp_sel = period_exp(src_hs,
        watchdog_mode_r[wdg_pkg::PERIOD_MSB:wdg_pkg::PERIOD_LSB]);

    // Counter pauses, not clears, while the source is not live
    assign cnt_tick = (state_r == wdg_pkg::WDG_RUN) && src_live && src_tick;
    assign cnt_clear = restart || (mode_wr && !mode_written_r);

    wdg_counter #(
        .CNT_W(CNT_W)
    ) u_counter (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clear(cnt_clear),
        .tick(cnt_tick),
        .exp_sel(exp_sel),
        .overflow(cnt_ovf),
        .count()
    );

    // Fire now, or once a stopped source clock resumes
    always_comb begin
        fire = 1'b0;
        if (state_r == wdg_pkg::WDG_RUN) begin
            if (cnt_ovf) begin
                fire = 1'b1;
            end
            if ((violation || pending_r) && src_live) begin
                fire = 1'b1;
            end
        end
    end

    // Violation seen with the source stopped is held until it resumes
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pending_r <= 1'b0;
        end else if (state_r != wdg_pkg::WDG_RUN) begin
            pending_r <= 1'b0;
        end else if (violation && !src_live) begin
            pending_r <= 1'b1;
        end else if (src_live) begin
            pending_r <= 1'b0;
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            wdg_pkg::WDG_RUN: begin
                if (fire) begin
                    state_nxt = wdg_pkg::WDG_FIRED;
                end else if (mode_wr && !mode_written_r && !opt_fixed_r
                        && bus_wdata[wdg_pkg::STOP_SEL_BIT]) begin
                    state_nxt = wdg_pkg::WDG_STOPPED;
                end
            end
            // Held until the system reset that the request triggers
            wdg_pkg::WDG_FIRED: begin
                state_nxt = wdg_pkg::WDG_FIRED;
            end
            // Write-once mode leaves no way back to counting
            wdg_pkg::WDG_STOPPED: begin
                state_nxt = wdg_pkg::WDG_STOPPED;
            end
            default: begin
                state_nxt = wdg_pkg::WDG_FIRED;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r <= wdg_pkg::WDG_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Reset request stays high until the external reset clears the block
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reset_req_r <= 1'b0;
        end else if (fire) begin
            reset_req_r <= 1'b1;
        end
    end

    // Cause flag: a new watchdog reset wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cause_flag_r <= 1'b0;
        end else if (fire) begin
            cause_flag_r <= 1'b1;
        end else if (cause_flag_clr) begin
            cause_flag_r <= 1'b0;
        end
    end

    // Read data is registered; unmapped addresses read zero
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 8'h00;
        end else if (bus_rd) begin
            if (sel_mode) begin
                rdata_r <= watchdog_mode_r;
            end else if (sel_key) begin
                rdata_r <= wdg_pkg::KEY_RST;
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end

    assign bus_rdata = rdata_r;
    assign wdt_reset_req = reset_req_r;
    assign watchdog_reset_cause_flag = cause_flag_r;
    assign wdt_counting = (state_r == wdg_pkg::WDG_RUN) && src_live;
endmodule

// >>> tb/wdg_chk.sv
// Port-level checker for the write-once watchdog
`timescale 1ns/1ps
module wdg_chk #(
    parameter int CNT_W = 21
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_bit_access,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_wait,
    input wire logic wdt_reset_req,
    input wire logic watchdog_reset_cause_flag,
    input wire logic wdt_counting
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire at_mode = bus_addr == wdg_pkg::MODE_ADDR;
    wire at_key = bus_addr == wdg_pkg::KEY_ADDR;
    wire wr_mode = bus_wr && !bus_bit_access && at_mode;
    wire rd_mode = bus_rd && !bus_bit_access && at_mode;
    wire wr_key = bus_wr && !bus_bit_access && at_key;
    wire rd_key = bus_rd && !bus_bit_access && at_key;
    logic wrote_r;
    logic [7:0] val_r;
    // Remembers the single accepted mode byte, later writes are refused
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wrote_r <= 1'b0;
            val_r <= 8'h00;
        end else if (wr_mode && !wrote_r) begin
            wrote_r <= 1'b1;
            val_r <= bus_wdata;
        end
    end
    wait_on_mode_a: assert property (bus_wait == (bus_wr && at_mode))
        else $error("bus wait does not follow mode writes");
    mode_reset_val_a: assert property (rd_mode && !wrote_r |=> bus_rdata == wdg_pkg::MODE_RST)
        else $error("mode read before write not at reset value");
    mode_readback_a: assert property (rd_mode && wrote_r |=>
        bus_rdata[7:5] == 3'h3 && bus_rdata[2:0] == val_r[2:0])
        else $error("mode read back differs from first write");
    mode_once_a: assert property (wr_mode && wrote_r && wdt_counting |=> wdt_reset_req)
        else $error("second mode write raised no reset");
    bad_key_a: assert property (wr_key && bus_wdata != wdg_pkg::KEY_RESTART && wdt_counting
        |=> wdt_reset_req)
        else $error("wrong key raised no reset");
    bit_key_a: assert property ((bus_wr || bus_rd) && bus_bit_access && at_key && wdt_counting
        |=> wdt_reset_req)
        else $error("bit access to key raised no reset");
    key_read_a: assert property (rd_key |=> bus_rdata == wdg_pkg::KEY_RST)
        else $error("key read not fixed value");
    flag_with_req_a: assert property ($rose(wdt_reset_req) |-> watchdog_reset_cause_flag)
        else $error("cause flag missing with reset request");
    req_sticky_a: assert property (wdt_reset_req |=> wdt_reset_req)
        else $error("reset request dropped");
endmodule
bind wdg_watchdog wdg_chk #(.CNT_W(CNT_W)) chk (.clk_sys(clk_sys), .resetn(resetn),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_bit_access(bus_bit_access),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_wait(bus_wait),
    .wdt_reset_req(wdt_reset_req), .watchdog_reset_cause_flag(watchdog_reset_cause_flag),
    .wdt_counting(wdt_counting));

// >>> tb/wdg_cpu_model.sv
// CPU core model issuing byte and bit register accesses
`timescale 1ns/1ps
module wdg_cpu_model (
    input wire logic clk_sys,
    output logic [15:0] bus_addr,
    output logic bus_wr,
    output logic bus_rd,
    output logic bus_bit_access,
    output logic [7:0] bus_wdata
);
    initial begin
        bus_addr = 16'h0000;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_bit_access = 1'b0;
        bus_wdata = 8'h00;
    end
    // One access per strobe cycle; data, top bits included, is driven as the caller gives it
    task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w,
                       input logic b);
        @(negedge clk_sys);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = w;
        bus_rd = !w;
        bus_bit_access = b;
        @(negedge clk_sys);
        // Released address and data lines show the inverse so stale values never look valid
        bus_addr = ~a;
        bus_wdata = ~d;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_bit_access = 1'b0;
    endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the write-once watchdog
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic strap = 1'b0;
    logic osc_run = 1'b1;
    logic stby = 1'b0;
    logic flag_clr = 1'b0;
    logic [15:0] addr;
    logic wr, rd, bit_acc, wait_o, req, flag, counting;
    logic [7:0] wdata, rdata;
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    localparam logic [15:0] M = wdg_pkg::MODE_ADDR;
    localparam logic [15:0] K = wdg_pkg::KEY_ADDR;
    always #25 clk_sys = ~clk_sys;
    wdg_cpu_model cpu (.clk_sys(clk_sys), .bus_addr(addr), .bus_wr(wr), .bus_rd(rd),
        .bus_bit_access(bit_acc), .bus_wdata(wdata));
    wdg_watchdog uut (.clk_sys(clk_sys), .resetn(resetn), .bus_addr(addr), .bus_wr(wr),
        .bus_rd(rd), .bus_bit_access(bit_acc), .bus_wdata(wdata), .bus_rdata(rdata),
        .bus_wait(wait_o), .osc_fixed_strap(strap), .internal_osc_clk(1'b1),
        .hs_clk_tick(1'b1), .int_osc_running(osc_run), .hs_clk_running(1'b1),
        .standby(stby), .cause_flag_clr(flag_clr), .wdt_reset_req(req),
        .watchdog_reset_cause_flag(flag), .wdt_counting(counting));
    task automatic give_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk1(string n, logic e, logic g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic do_reset(logic s);
        @(negedge clk_sys);
        resetn = 1'b0;
        strap = s;
        osc_run = 1'b1;
        stby = 1'b0;
        flag_clr = 1'b0;
        repeat (4) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic t_regs();
        do_reset(1'b0);
        cpu.acc(M, 8'h00, 1'b0, 1'b0);
        chk8("mode", 8'h67, rdata);
        cpu.acc(K, 8'hac, 1'b1, 1'b0);
        cpu.acc(K, 8'h00, 1'b0, 1'b0);
        chk8("key", 8'h9a, rdata);
        cpu.acc(M, 8'h68, 1'b1, 1'b0);
        repeat (2) begin
            cpu.acc(M, 8'h00, 1'b0, 1'b0);
            chk8("mode", 8'h68, rdata);
        end
        chk1("counting", 1'b1, counting);
        chk1("req", 1'b0, req);
        // Fast clock, code 0: 2^13 ticks, far beyond the oscillator's 2^11
        repeat (8000) @(negedge clk_sys);
        chk1("req", 1'b0, req);
        repeat (300) @(negedge clk_sys);
        chk1("req", 1'b1, req);
        $display("t_regs done");
    endtask
    task automatic t_overflow();
        do_reset(1'b0);
        cpu.acc(M, 8'h60, 1'b1, 1'b0);
        repeat (1500) @(negedge clk_sys);
        cpu.acc(K, 8'hac, 1'b1, 1'b0);
        repeat (1500) @(negedge clk_sys);
        chk1("req", 1'b0, req);
        repeat (600) @(negedge clk_sys);
        chk1("req", 1'b1, req);
        chk1("flag", 1'b1, flag);
        $display("t_overflow done");
    endtask
    task automatic t_second_write();
        do_reset(1'b0);
        cpu.acc(M, 8'h61, 1'b1, 1'b0);
        chk1("req", 1'b0, req);
        cpu.acc(M, 8'h62, 1'b1, 1'b0);
        @(negedge clk_sys);
        chk1("req", 1'b1, req);
        $display("t_second_write done");
    endtask
    task automatic t_bad_key();
        for (int i = 0; i < 3; i++) begin
            do_reset(1'b0);
            cpu.acc(K, (i == 2) ? 8'hac : 8'h00, i != 1, i != 0);
            @(negedge clk_sys);
            chk1("req", 1'b1, req);
        end
        $display("t_bad_key done");
    endtask
    task automatic t_stop();
        do_reset(1'b0);
        cpu.acc(M, 8'h70, 1'b1, 1'b0);
        chk1("counting", 1'b0, counting);
        cpu.acc(M, 8'h60, 1'b1, 1'b0);
        cpu.acc(K, 8'h00, 1'b1, 1'b0);
        cpu.acc(K, 8'h00, 1'b0, 1'b1);
        repeat (5) @(negedge clk_sys);
        chk1("req", 1'b0, req);
        chk1("counting", 1'b0, counting);
        $display("t_stop done");
    endtask
    task automatic t_fixed();
        do_reset(1'b1);
        cpu.acc(M, 8'h98, 1'b1, 1'b0);
        cpu.acc(M, 8'h00, 1'b0, 1'b0);
        chk8("mode", 8'h60, rdata);
        chk1("counting", 1'b1, counting);
        $display("t_fixed done");
    endtask
    task automatic t_hold();
        do_reset(1'b0);
        osc_run = 1'b0;
        cpu.acc(K, 8'h00, 1'b1, 1'b0);
        repeat (5) @(negedge clk_sys);
        chk1("req", 1'b0, req);
        osc_run = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk1("req", 1'b1, req);
        $display("t_hold done");
    endtask
    // 1000 ticks, pause, then 1100 more: fires only if the count was kept
    task automatic t_standby();
        do_reset(1'b0);
        cpu.acc(M, 8'h60, 1'b1, 1'b0);
        repeat (1000) @(negedge clk_sys);
        stby = 1'b1;
        @(negedge clk_sys);
        chk1("counting", 1'b0, counting);
        repeat (1999) @(negedge clk_sys);
        stby = 1'b0;
        repeat (900) @(negedge clk_sys);
        chk1("req", 1'b0, req);
        repeat (200) @(negedge clk_sys);
        chk1("req", 1'b1, req);
        chk1("flag", 1'b1, flag);
        flag_clr = 1'b1;
        @(negedge clk_sys);
        flag_clr = 1'b0;
        chk1("flag", 1'b0, flag);
        chk1("req", 1'b1, req);
        $display("t_standby done");
    endtask
    initial begin
        t_regs();
        t_overflow();
        t_second_write();
        t_bad_key();
        t_stop();
        t_fixed();
        t_hold();
        t_standby();
        give_verdict();
    end
endmodule
